// ### src/vot_pkg.sv
`default_nettype none
package vot_pkg;
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_CTRL03 = 8'h03;
  localparam logic [7:0] IDX_SHARED = 8'h0f;
  localparam logic [7:0] IDX_START_HI = 8'h11;
  localparam logic [7:0] IDX_START_LO = 8'h12;
  localparam logic [7:0] IDX_STOP_HI = 8'h13;
  localparam logic [7:0] IDX_STOP_LO = 8'h14;
  localparam logic [7:0] IDX_SYNC_CTRL = 8'h15;
  localparam logic [7:0] IDX_VB_START = 8'h18;
  localparam logic [7:0] IDX_VB_STOP = 8'h19;
  localparam logic [7:0] IDX_INDEX = 8'h20;
  localparam logic [7:0] IDX_DATA = 8'h21;
  localparam logic [7:0] IDX_STATUS = 8'h22;
  // reset values
  localparam logic [7:0] RST_SHARED = 8'h08;
  localparam logic [7:0] RST_SYNC_CTRL = 8'h01;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // shared pin config fields
  localparam int SP_FID_LOCK = 7;
  localparam int SP_LINE_LOCK = 6;
  localparam int SP_FID_SUBCARRIER_LOCK_SERIAL_OUT = 3;
  localparam int SP_VS_LINE = 2;
  localparam int SP_REQ_ALT = 1;
  localparam int SP_PCLK = 0;
  // control 03 fields
  localparam int C3_VERTICAL_BLANK_OUT = 7;
  localparam int C3_GENERAL_PURPOSE_CTRL_OUT = 6;
  // start low field
  localparam int SL_ACT_VB = 7;
  // sync/lock output control fields
  localparam int SC_STABLE = 7;
  localparam int SC_FV_HI = 5;
  localparam int SC_FV_LO = 4;
  localparam int SC_AUTOINC = 3;
  localparam int SC_MODE1 = 2;
  localparam int SC_RTC = 0;
  // flag control codes
  localparam logic [1:0] FV_AUTO = 2'h0;
  localparam logic [1:0] FV_TOGGLE = 2'h1;
  localparam logic [1:0] FV_PULSE = 2'h2;
  // horizontal timing in output clocks
  localparam logic [10:0] HS_DELAY_NTSC = 11'd16;
  localparam logic [10:0] HS_DELAY_PAL = 11'd20;
  localparam logic [10:0] HS_DELAY_SECAM = 11'd40;
  localparam logic [10:0] BLANK_NTSC = 11'd272;
  localparam logic [10:0] BLANK_PAL = 11'd284;
  localparam logic [10:0] BLANK_SECAM = 11'd280;
  localparam logic [10:0] ACT_PIX_COUNT = 11'd1440;
  localparam logic [10:0] HS_WIDTH = 11'd64;
  // back-door memory
  localparam int MEM_AW = 4;
  localparam int MEM_DEPTH = 16;
  typedef enum logic [1:0] {STD_NTSC = 2'h0, STD_PAL = 2'h1, STD_SECAM = 2'h2} vot_std_type;
  typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_DONE = 2'b10} vot_bus_type;
endpackage
`default_nettype wire

// ### src/vot_mem_if.sv
`default_nettype none
interface vot_mem_if;
  logic ce;
  logic we;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output ce, output we, output addr, output wdata, input rdata);
  modport mem (input ce, input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ### src/vot_backdoor_mem.sv
`default_nettype none
module vot_backdoor_mem
  import vot_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  vot_mem_if.mem bus
);
  typedef struct packed {
    logic [MEM_DEPTH-1:0][7:0] word;
    logic [7:0] rdata;
  } vot_mem_state_type;
  vot_mem_state_type r_reg;
  vot_mem_state_type r_next;

  always_comb begin
    r_next = r_reg;
    if (bus.ce) begin
      if (bus.we) begin
        r_next.word[bus.addr] = bus.wdata;
      end
      r_next.rdata = r_reg.word[bus.addr];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign bus.rdata = r_reg.rdata;
endmodule
`default_nettype wire

// ### src/vot_top.sv
// The APB register port was chosen for this implementation.
`default_nettype none
module vot_top
  import vot_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pix_ce,
  input wire logic [1:0] std_sel,
  input wire logic line_start,
  input wire logic field_start,
  input wire logic field_in,
  input wire logic vblank_in,
  input wire logic vsync_in,
  input wire logic alternating_line_flag,
  input wire logic vlock_in,
  input wire logic hlock_in,
  input wire logic subcarrier_lock_serial_out,
  input wire logic interrupt_request_out,
  input wire logic std_lines_in,
  input wire logic odd_lines_in,
  output logic field_identity_out,
  output logic sync_pin_out,
  output logic request_pin_out,
  output logic clk_pin_out,
  output logic active_window_flag,
  output logic hsync_out,
  output logic vflag_out,
  output logic fflag_out,
  output logic rtc_select_out,
  output logic rtc_mode1_out
);
  typedef struct packed {
    vot_bus_type bus;
    logic pready;
    logic pslverr;
    logic [7:0] prdata;
    logic [7:0] shared;
    logic [7:0] start_hi;
    logic [7:0] start_lo;
    logic [7:0] stop_hi;
    logic [7:0] stop_lo;
    logic [7:0] sync_ctrl;
    logic [7:0] ctrl03;
    logic [7:0] vbs;
    logic [7:0] vbe;
    logic [3:0] index;
    logic [9:0] start_val;
    logic [9:0] stop_val;
    logic [10:0] pix;
    logic [9:0] lc;
    logic [9:0] vb_rise;
    logic [9:0] vb_fall;
    logic [9:0] act_lines;
    logic vb_prev;
    logic v_ns;
    logic f_tog;
    logic clk_div;
    logic field_pin;
    logic sync_pin;
    logic req_pin;
    logic clk_pin;
    logic act;
    logic hs;
    logic vf;
    logic ff;
    logic rtc_m1;
  } vot_state_type;

  vot_state_type r_reg;
  vot_state_type r_next;
  vot_mem_if mem_if ();

  logic [7:0] idx;
  logic hit;
  logic done;
  logic [7:0] rd_data;
  logic rd_ok;
  logic [10:0] blank;
  logic [10:0] hs_delay;
  logic signed [12:0] pix_s;
  logic signed [12:0] start_pos;
  logic signed [12:0] stop_pos;
  logic signed [12:0] lc_s;
  logic signed [12:0] vb_lo;
  logic signed [12:0] vb_hi;
  logic vertical_blank_out;
  logic v_src;
  logic [10:0] act_end;
  logic [1:0] fv_code;

  function automatic logic signed [12:0] sext10(input logic [9:0] v);
    sext10 = $signed({{3{v[9]}}, v});
  endfunction

  function automatic logic signed [12:0] sext8(input logic [7:0] v);
    sext8 = $signed({{5{v[7]}}, v});
  endfunction

  assign idx = paddr[9:2];
  assign hit = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign done = r_reg.pready && psel && penable;
  assign mem_if.ce = ce;
  assign mem_if.addr = r_reg.index;
  assign mem_if.wdata = pwdata[7:0];
  assign mem_if.we = done && pwrite && hit && (idx == IDX_DATA);

  vot_backdoor_mem u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .bus(mem_if.mem)
  );

  always_comb begin
    case (std_sel)
      STD_PAL: begin
        blank = BLANK_PAL;
        hs_delay = HS_DELAY_PAL;
      end
      STD_SECAM: begin
        blank = BLANK_SECAM;
        hs_delay = HS_DELAY_SECAM;
      end
      default: begin
        blank = BLANK_NTSC;
        hs_delay = HS_DELAY_NTSC;
      end
    endcase
  end

  always_comb begin
    rd_ok = hit;
    case (idx)
      IDX_CTRL03: rd_data = r_reg.ctrl03;
      IDX_SHARED: rd_data = r_reg.shared;
      IDX_START_HI: rd_data = r_reg.start_hi;
      IDX_START_LO: rd_data = r_reg.start_lo;
      IDX_STOP_HI: rd_data = r_reg.stop_hi;
      IDX_STOP_LO: rd_data = r_reg.stop_lo;
      IDX_SYNC_CTRL: rd_data = r_reg.sync_ctrl;
      IDX_VB_START: rd_data = r_reg.vbs;
      IDX_VB_STOP: rd_data = r_reg.vbe;
      IDX_INDEX: rd_data = {4'h0, r_reg.index};
      IDX_DATA: rd_data = mem_if.rdata;
      IDX_STATUS: rd_data = {4'h0, vlock_in, hlock_in, r_reg.vf, r_reg.ff};
      default: begin
        rd_data = 8'h00;
        rd_ok = 1'b0;
      end
    endcase
  end

  // window and blanking geometry
  assign pix_s = $signed({2'b00, r_reg.pix});
  assign start_pos = $signed({2'b00, blank}) + sext10(r_reg.start_val);
  assign stop_pos = $signed({2'b00, blank + ACT_PIX_COUNT}) + sext10(r_reg.stop_val);
  assign lc_s = $signed({3'b000, r_reg.lc});
  assign vb_lo = $signed({3'b000, r_reg.vb_rise}) + sext8(r_reg.vbs);
  assign vb_hi = $signed({3'b000, r_reg.vb_fall}) + sext8(r_reg.vbe);
  assign vertical_blank_out = (lc_s >= vb_lo) && (lc_s < vb_hi);
  assign act_end = {1'b0, r_reg.vb_fall} + {1'b0, r_reg.act_lines};
  assign fv_code = r_reg.sync_ctrl[SC_FV_HI:SC_FV_LO];

  always_comb begin
    if (!std_lines_in) begin
      v_src = r_reg.v_ns;
    end else if (r_reg.sync_ctrl[SC_STABLE]) begin
      v_src = !(({1'b0, r_reg.lc} >= {1'b0, r_reg.vb_fall}) && ({1'b0, r_reg.lc} < act_end));
    end else begin
      v_src = vblank_in;
    end
  end

  always_comb begin
    r_next = r_reg;
    case (r_reg.bus)
      BUS_IDLE: begin
        if (psel && penable) begin
          r_next.pready = 1'b1;
          r_next.pslverr = !rd_ok;
          r_next.prdata = (pwrite || !rd_ok) ? 8'h00 : rd_data;
          r_next.bus = BUS_DONE;
        end
      end
      BUS_DONE: begin
        r_next.pready = 1'b0;
        r_next.pslverr = 1'b0;
        r_next.bus = BUS_IDLE;
        if (done && hit && pwrite) begin
          case (idx)
            IDX_CTRL03: r_next.ctrl03 = pwdata[7:0];
            IDX_SHARED: r_next.shared = pwdata[7:0];
            IDX_START_HI: r_next.start_hi = pwdata[7:0];
            IDX_START_LO: begin
              r_next.start_lo = pwdata[7:0];
              r_next.start_val = {r_reg.start_hi, pwdata[1:0]};
            end
            IDX_STOP_HI: r_next.stop_hi = pwdata[7:0];
            IDX_STOP_LO: begin
              r_next.stop_lo = pwdata[7:0];
              r_next.stop_val = {r_reg.stop_hi, pwdata[1:0]};
            end
            IDX_SYNC_CTRL: r_next.sync_ctrl = pwdata[7:0];
            IDX_VB_START: r_next.vbs = pwdata[7:0];
            IDX_VB_STOP: r_next.vbe = pwdata[7:0];
            IDX_INDEX: r_next.index = pwdata[3:0];
            default: r_next.index = r_reg.index;
          endcase
        end
        if (done && hit && (idx == IDX_DATA) && r_reg.sync_ctrl[SC_AUTOINC]) begin
          r_next.index = r_reg.index + 4'h1;
        end
      end
      default: begin
        r_next.bus = BUS_IDLE;
        r_next.pready = 1'b0;
      end
    endcase

    // pixel and line counters
    if (pix_ce) begin
      r_next.vb_prev = vblank_in;
      r_next.clk_div = !r_reg.clk_div;
      if (!r_reg.shared[SP_PCLK] || r_reg.clk_div) begin
        r_next.clk_pin = !r_reg.clk_pin;
      end
      if (line_start) begin
        r_next.pix = 11'h000;
        r_next.lc = r_reg.lc + 10'h001;
      end else if (r_reg.pix != 11'h7ff) begin
        r_next.pix = r_reg.pix + 11'h001;
      end
      if (field_start) begin
        r_next.lc = 10'h000;
        r_next.v_ns = 1'b1;
        r_next.f_tog = !r_reg.f_tog;
      end
      if (vblank_in && !r_reg.vb_prev) begin
        r_next.vb_rise = r_reg.lc;
        if (!r_reg.sync_ctrl[SC_STABLE]) begin
          r_next.act_lines = r_reg.lc - r_reg.vb_fall;
        end
      end
      if (!vblank_in && r_reg.vb_prev) begin
        r_next.vb_fall = r_reg.lc;
        r_next.v_ns = 1'b0;
      end
    end

    // pin multiplexing
    if (r_reg.shared[SP_FID_SUBCARRIER_LOCK_SERIAL_OUT]) begin
      r_next.field_pin = subcarrier_lock_serial_out;
    end else if (r_reg.shared[SP_FID_LOCK]) begin
      r_next.field_pin = vlock_in;
    end else begin
      r_next.field_pin = field_in;
    end
    if (!r_reg.shared[SP_VS_LINE]) begin
      r_next.sync_pin = vsync_in;
    end else if (r_reg.shared[SP_LINE_LOCK]) begin
      r_next.sync_pin = hlock_in;
    end else begin
      r_next.sync_pin = alternating_line_flag;
    end
    if (!r_reg.shared[SP_REQ_ALT]) begin
      r_next.req_pin = interrupt_request_out;
    end else if (r_reg.ctrl03[C3_VERTICAL_BLANK_OUT]) begin
      r_next.req_pin = vertical_blank_out;
    end else begin
      r_next.req_pin = r_reg.ctrl03[C3_GENERAL_PURPOSE_CTRL_OUT];
    end

    // timing flags
    r_next.hs = ({1'b0, r_reg.pix} >= {1'b0, hs_delay}) &&
                ({1'b0, r_reg.pix} < ({1'b0, hs_delay} + {1'b0, HS_WIDTH}));
    r_next.vf = v_src;
    r_next.act = (pix_s >= start_pos) && (pix_s < stop_pos) &&
                 !(r_reg.start_lo[SL_ACT_VB] && r_reg.vf);
    if (std_lines_in) begin
      r_next.ff = field_in;
    end else begin
      case (fv_code)
        FV_TOGGLE: r_next.ff = r_reg.f_tog;
        FV_PULSE: r_next.ff = (r_reg.lc == 10'h000);
        default: r_next.ff = odd_lines_in ? r_reg.f_tog : 1'b1;
      endcase
    end
    r_next.rtc_m1 = r_next.sync_ctrl[SC_RTC] & r_next.sync_ctrl[SC_MODE1];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
      r_reg.bus <= BUS_IDLE;
      r_reg.shared <= RST_SHARED;
      r_reg.sync_ctrl <= RST_SYNC_CTRL;
      r_reg.start_val <= 10'h000;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  assign prdata = {24'h000000, r_reg.prdata};
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign field_identity_out = r_reg.field_pin;
  assign sync_pin_out = r_reg.sync_pin;
  assign request_pin_out = r_reg.req_pin;
  assign clk_pin_out = r_reg.clk_pin;
  assign active_window_flag = r_reg.act;
  assign hsync_out = r_reg.hs;
  assign vflag_out = r_reg.vf;
  assign fflag_out = r_reg.ff;
  assign rtc_select_out = r_reg.sync_ctrl[SC_RTC];
  assign rtc_mode1_out = r_reg.rtc_m1;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_start_commit: assert property (ce && done && pwrite && hit && idx == IDX_START_LO |=>
    r_reg.start_val == {$past(r_reg.start_hi), $past(pwdata[1:0])}) else $error("start not committed");
  a_start_shadow: assert property (ce && done && pwrite && idx == IDX_START_HI |=>
    $stable(r_reg.start_val)) else $error("start changed on high write");
  a_stop_commit: assert property (ce && done && pwrite && hit && idx == IDX_STOP_LO |=>
    r_reg.stop_val == {$past(r_reg.stop_hi), $past(pwdata[1:0])}) else $error("stop not committed");
  a_index_autoinc: assert property (ce && done && hit && idx == IDX_DATA && r_reg.sync_ctrl[3] |=>
    r_reg.index == $past(r_reg.index) + 4'h1) else $error("index not advanced");
  a_field_lock_pin: assert property (ce && !r_reg.shared[3] && r_reg.shared[7] |=>
    field_identity_out == $past(vlock_in)) else $error("field pin not lock");
  a_field_subcarrier_lock_serial_out_pin: assert property (ce && r_reg.shared[3] |=>
    field_identity_out == $past(subcarrier_lock_serial_out)) else $error("field pin not genlock");
  a_sync_pin_mux: assert property (ce && r_reg.shared[2] && r_reg.shared[6] |=>
    sync_pin_out == $past(hlock_in)) else $error("sync pin not lock");
  a_vsync_pin_mux: assert property (ce && !r_reg.shared[2] |=>
    sync_pin_out == $past(vsync_in)) else $error("sync pin not vsync");
  a_req_pin_mux: assert property (ce && !r_reg.shared[1] |=>
    request_pin_out == $past(interrupt_request_out)) else $error("request pin wrong");
  a_clk_fast: assert property (ce && pix_ce && !r_reg.shared[0] |=>
    clk_pin_out != $past(clk_pin_out)) else $error("fast clock stalled");
  a_act_vblank: assert property (ce && r_reg.start_lo[7] && r_reg.vf |=>
    !active_window_flag) else $error("active flag in vblank");
  a_rtc_mode: assert property (rtc_mode1_out |-> rtc_select_out)
    else $error("rtc mode without rtc select");
  a_pready_pulse: assert property (pready && ce |=> !pready) else $error("pready held");

  c_start_write: cover property (ce && done && pwrite && idx == IDX_START_LO);
  c_data_read: cover property (ce && done && !pwrite && idx == IDX_DATA);
  c_vblank_pin: cover property (r_reg.shared[1] && r_reg.ctrl03[7] && request_pin_out);
  c_half_clock: cover property (r_reg.shared[0] && pix_ce && ce);
endmodule
`default_nettype wire

// ### test/vot_host.sv
`default_nettype none
module vot_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rdata;
  logic rerr;
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
  end
  // setup then access, held until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
endmodule
`default_nettype wire

// ### test/vot_top_tb.sv
`default_nettype none
`define CHK(g, e) begin \
  checks++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("mismatch %0t got %0h exp %0h", $time, g, e); \
  end \
end
module vot_top_tb;
  import vot_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pix_ce, line_start, field_start, field_in, vblank_in, vsync_in, alternating_line_flag;
  logic vlock_in, hlock_in, subcarrier_lock_serial_out, interrupt_request_out;
  logic std_lines_in, odd_lines_in, field_identity_out, sync_pin_out, request_pin_out;
  logic clk_pin_out, active_window_flag, hsync_out, vflag_out, fflag_out;
  logic rtc_select_out, rtc_mode1_out, last, gp, e1, e2;
  logic [1:0] std_sel;
  logic [7:0] sh;
  logic [7:0] model [int];
  logic [7:0] q [$];
  logic [31:0] seed = 32'h2815;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  int r0, w0, h0, r, w, hr, hw, n;
  int hd[3] = '{16, 20, 40};
  int bl[3] = '{272, 284, 280};

  vot_host host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  vot_top uut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pix_ce, .std_sel, .line_start, .field_start, .field_in, .vblank_in,
    .vsync_in, .alternating_line_flag, .vlock_in, .hlock_in, .subcarrier_lock_serial_out,
    .interrupt_request_out, .std_lines_in, .odd_lines_in, .field_identity_out, .sync_pin_out,
    .request_pin_out, .clk_pin_out, .active_window_flag, .hsync_out, .vflag_out, .fflag_out,
    .rtc_select_out, .rtc_mode1_out);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic print_verdict();
    $display("counts: checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    host.xfer(1'h1, {2'h0, idx, 2'h0}, {24'h0, d});
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic er);
    host.xfer(1'h0, {2'h0, idx, 2'h0}, 32'h0);
    `CHK(host.rdata, {24'h0, e})
    `CHK(host.rerr, er)
  endtask

  // one line from line_start: window and hsync positions
  task automatic line(output int rs, output int wd, output int hs, output int hwd);
    rs = -1;
    wd = 0;
    hs = -1;
    hwd = 0;
    line_start <= 1'h1;
    @(posedge pclk);
    line_start <= 1'h0;
    @(posedge pclk);
    for (int i = 0; i < 2400; i++) begin
      @(posedge pclk);
      if (active_window_flag === 1'h1) begin
        if (rs < 0) rs = i;
        wd++;
      end
      if (hsync_out === 1'h1) begin
        if (hs < 0) hs = i;
        hwd++;
      end
    end
  endtask

  task automatic chk_line(input int s, input int p);
    line(r, w, hr, hw);
    `CHK(r, r0 + s)
    `CHK(w, w0 + p - s)
  endtask

  // one-cycle field (f=1) or line (f=0) strobes
  task automatic strobe(input logic f, input int k);
    repeat (k) begin
      {field_start, line_start} <= {f, !f};
      @(posedge pclk);
      {field_start, line_start} <= 2'h0;
      @(posedge pclk);
    end
  endtask

  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      print_verdict();
    end
  end

  initial begin
    presetn = 1'h0;
    ce = 1'h1;
    pix_ce = 1'h0;
    line_start = 1'h0;
    std_sel = 2'h0;
    {field_in, vsync_in, alternating_line_flag, vlock_in, hlock_in, vblank_in} = 6'h0;
    {subcarrier_lock_serial_out, interrupt_request_out, field_start} = 3'h0;
    {std_lines_in, odd_lines_in} = 2'h0;
    model[IDX_SHARED] = RST_SHARED;
    model[IDX_SYNC_CTRL] = RST_SYNC_CTRL;
    model[IDX_START_HI] = RST_ZERO;
    model[IDX_START_LO] = RST_ZERO;
    model[IDX_STOP_HI] = RST_ZERO;
    model[IDX_STOP_LO] = RST_ZERO;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    foreach (model[i]) rd(8'(i), model[i], 1'h0);
    `CHK(rtc_select_out, 1'h1)
    rd(8'h10, 8'h00, 1'h1);
    host.xfer(1'h0, 12'h03d, 32'h0);
    `CHK(host.rerr, 1'h1)
    `CHK(host.rdata, 32'h0)
    foreach (model[i]) begin
      seed = lfsr(seed);
      model[i] = seed[7:0];
      wr(8'(i), model[i]);
      rd(8'(i), model[i], 1'h0);
    end
    $display("test registers done");
    for (int v = 0; v < 8; v++) begin
      wr(IDX_SYNC_CTRL, 8'(v));
      repeat (2) @(posedge pclk);
      `CHK(rtc_select_out, v[0])
      `CHK(rtc_mode1_out, v[0] & v[2])
    end
    wr(IDX_SYNC_CTRL, 8'h09);
    wr(IDX_INDEX, 8'h02);
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      q.push_back(seed[7:0]);
      wr(IDX_DATA, seed[7:0]);
    end
    wr(IDX_INDEX, 8'h02);
    foreach (q[k]) rd(IDX_DATA, q[k], 1'h0);
    wr(IDX_SYNC_CTRL, 8'h01);
    wr(IDX_INDEX, 8'h02);
    repeat (2) rd(IDX_DATA, q[0], 1'h0);
    $display("test window memory done");
    for (int k = 0; k < 16; k++) begin
      seed = lfsr(seed);
      sh = seed[7:0];
      gp = seed[8];
      wr(IDX_SHARED, sh);
      wr(IDX_CTRL03, {1'h0, gp, 6'h0});
      seed = lfsr(seed);
      {field_in, vsync_in, alternating_line_flag, vlock_in, hlock_in} <= seed[4:0];
      {subcarrier_lock_serial_out, interrupt_request_out, field_start} <= seed[7:5];
      {std_lines_in, odd_lines_in} <= seed[9:8];
      repeat (3) @(posedge pclk);
      e1 = sh[7] ? vlock_in : field_in;
      e2 = sh[6] ? hlock_in : alternating_line_flag;
      `CHK(field_identity_out, sh[3] ? subcarrier_lock_serial_out : e1)
      `CHK(sync_pin_out, sh[2] ? e2 : vsync_in)
      `CHK(request_pin_out, sh[1] ? gp : interrupt_request_out)
    end
    $display("test shared pins done");
    for (int m = 0; m < 2; m++) begin
      wr(IDX_SHARED, 8'(m));
      repeat (2) @(posedge pclk);
      n = 0;
      last = clk_pin_out;
      for (int j = 0; j < 52; j++) begin
        pix_ce <= (j % 4 == 0) && (j < 48);
        @(posedge pclk);
        if (clk_pin_out !== last) n++;
        last = clk_pin_out;
      end
      `CHK(n, m ? 6 : 12)
    end
    $display("test output clock done");
    pix_ce <= 1'h1;
    {vblank_in, field_start, std_lines_in} <= 3'h1;
    wr(IDX_START_HI, 8'h00);
    wr(IDX_START_LO, 8'h00);
    wr(IDX_STOP_HI, 8'h00);
    wr(IDX_STOP_LO, 8'h00);
    line(r0, w0, h0, hw);
    `CHK(r0, bl[0])
    `CHK(h0, hd[0])
    `CHK(hw, 64)
    for (int k = 1; k < 3; k++) begin
      std_sel <= 2'(k);
      line(r, w, hr, hw);
      `CHK(hr - h0, hd[k] - hd[0])
      `CHK(r - r0, bl[k] - bl[0])
      `CHK(hw, 64)
    end
    std_sel <= 2'h0;
    wr(IDX_START_HI, 8'h01);
    chk_line(0, 0);
    wr(IDX_START_LO, 8'h02);
    chk_line(6, 0);
    wr(IDX_STOP_HI, 8'hff);
    chk_line(6, 0);
    wr(IDX_STOP_LO, 8'h00);
    chk_line(6, -4);
    wr(IDX_STOP_HI, 8'h80);
    wr(IDX_STOP_LO, 8'h01);
    wr(IDX_START_HI, 8'h7f);
    wr(IDX_START_LO, 8'h03);
    chk_line(511, -511);
    vblank_in <= 1'h1;
    wr(IDX_START_LO, 8'h83);
    line(r, w, hr, hw);
    `CHK(r, -1)
    vblank_in <= 1'h0;
    chk_line(511, -511);
    $display("test active window done");
    {std_lines_in, odd_lines_in, field_in} <= 3'h0;
    wr(IDX_SYNC_CTRL, 8'h31);
    repeat (2) @(posedge pclk);
    `CHK(fflag_out, 1'h1)
    wr(IDX_SYNC_CTRL, 8'h11);
    repeat (2) @(posedge pclk);
    last = fflag_out;
    strobe(1'h1, 1);
    @(posedge pclk);
    `CHK(fflag_out, !last)
    wr(IDX_SYNC_CTRL, 8'h21);
    strobe(1'h1, 1);
    @(posedge pclk);
    `CHK(fflag_out, 1'h1)
    strobe(1'h0, 1);
    @(posedge pclk);
    `CHK(fflag_out, 1'h0)
    {std_lines_in, field_in, vblank_in} <= 3'h7;
    repeat (2) @(posedge pclk);
    `CHK(fflag_out, 1'h1)
    `CHK(vflag_out, 1'h1)
    {field_in, vblank_in} <= 2'h0;
    repeat (2) @(posedge pclk);
    `CHK(vflag_out, 1'h0)
    wr(IDX_SHARED, 8'h02);
    wr(IDX_CTRL03, 8'h80);
    wr(IDX_VB_START, 8'h00);
    wr(IDX_VB_STOP, 8'hfe);
    strobe(1'h1, 1);
    vblank_in <= 1'h1;
    strobe(1'h0, 4);
    vblank_in <= 1'h0;
    strobe(1'h1, 1);
    repeat (2) @(posedge pclk);
    `CHK(request_pin_out, 1'h1)
    strobe(1'h0, 2);
    repeat (2) @(posedge pclk);
    `CHK(request_pin_out, 1'h0)
    ce <= 1'h0;
    @(posedge pclk);
    last = clk_pin_out;
    repeat (3) @(posedge pclk);
    `CHK(clk_pin_out, last)
    ce <= 1'h1;
    @(posedge pclk);
    $display("test flags done");
    print_verdict();
  end
endmodule
`default_nettype wire
